//--- rtl/pfs_pin_function_select.sv
// Overview of operation
// - Port D register 16-bit RW, reset AA8A
// - Only power-on reset initialises the registers
// - Pin n uses bits 2n+1 and 2n
// - Port D codes: alt, output, two inputs
// - Port D pin 2 resets to alternate function
// - Port D pins 4,6: no output, reset 10
// - Port E resets AAAA normal, 2AA8 debug
// - Port E pins 0,7: 00 reserved, debug 00
// - Port E pins 1-6: alt on 2,4,5 only
// - Port F resets AAAA normal, 00AA debug
// - Port F pins 4-7: no output, debug 00
// - Port F pins 0-3: no output, reset 10
// - Strap sampled during reset selects debug mode
`include "pfs_consts.svh"
`default_nettype none

module pfs_pin_function_select
	import pfs_pkg::*;
(
	input wire logic pclk, // System clock, 20 MHz
	input wire logic presetn, // Power-on reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high = write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB write byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic debug_mode_strap, // Low during reset = debug mode
	output logic debug_mode, // Debug mode was strapped
	output logic [7:0] port_d_alt_sel, // Port D peripheral select
	output logic [7:0] port_d_out_en, // Port D output enable
	output logic [7:0] port_d_pullup_en, // Port D pull-up enable
	output logic [7:0] port_e_alt_sel, // Port E peripheral select
	output logic [7:0] port_e_out_en, // Port E output enable
	output logic [7:0] port_e_pullup_en, // Port E pull-up enable
	output logic [7:0] port_f_alt_sel, // Port F peripheral select
	output logic [7:0] port_f_out_en, // Port F output enable
	output logic [7:0] port_f_pullup_en // Port F pull-up enable
);

	// ==================================================================
	// Declarations
	logic strap_reg; // Strap level seen while reset is held
	logic strap_next; // Next strap capture
	logic debug_mode_reg; // Debug mode flag
	logic debug_mode_next; // Next debug mode flag
	pfs_init_t init_reg; // Init phase
	pfs_init_t init_next; // Next init phase
	logic init_load; // One-cycle load of strap values
	logic pready_reg; // Registered ready
	logic pready_next; // Next ready
	logic pslverr_reg; // Registered error
	logic pslverr_next; // Next error
	logic [31:0] prdata_reg; // Registered read data
	logic [31:0] prdata_next; // Next read data
	logic access; // Access phase in progress
	logic commit; // Transfer completes this edge
	logic hit_d; // Address selects port D
	logic hit_e; // Address selects port E
	logic hit_f; // Address selects port F
	logic wr_d; // Write port D
	logic wr_e; // Write port E
	logic wr_f; // Write port F
	logic [15:0] load_e; // Strap-dependent E value
	logic [15:0] load_f; // Strap-dependent F value
	logic [15:0] fn_d; // Port D contents
	logic [15:0] fn_e; // Port E contents
	logic [15:0] fn_f; // Port F contents

	// ==================================================================
	// Strap capture: plain flop, loads only while reset is low, so
	// no async reset may carry the pin value into it
	always_comb begin
		strap_next = strap_reg;
		if (!presetn) begin
			strap_next = debug_mode_strap;
		end
	end

	// Registered with no reset of its own
	always_ff @(posedge pclk) begin
		strap_reg <= strap_next;
	end

	// ==================================================================
	// Init sequencing: the first edge after release applies the
	// strap-dependent values, after which the registers are free
	always_comb begin
		init_next = init_reg;
		debug_mode_next = debug_mode_reg;
		init_load = 1'b0;
		case (init_reg)
			PFS_INIT_LOAD: begin
				init_load = 1'b1;
				debug_mode_next = !strap_reg;
				init_next = PFS_INIT_RUN;
			end
			PFS_INIT_RUN: begin
				init_load = 1'b0;
			end
			default: begin
				init_next = PFS_INIT_LOAD;
			end
		endcase
	end

	// Init state, reset only by power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_reg <= PFS_INIT_LOAD;
			debug_mode_reg <= 1'b0;
		end else begin
			init_reg <= init_next;
			debug_mode_reg <= debug_mode_next;
		end
	end

	// Strap-dependent values for E and F
	always_comb begin
		if (!strap_reg) begin
			load_e = `PFS_RST_PORT_E_DEBUG;
			load_f = `PFS_RST_PORT_F_DEBUG;
		end else begin
			load_e = `PFS_RST_PORT_E_NORMAL;
			load_f = `PFS_RST_PORT_F_NORMAL;
		end
	end

	// ==================================================================
	// APB slave: one wait state, ready rises in the second access
	// cycle; writes land only on the completing edge
	assign access = psel && penable;
	assign commit = access && pready_reg;
	assign hit_d = (paddr == `PFS_OFS_PORT_D);
	assign hit_e = (paddr == `PFS_OFS_PORT_E);
	assign hit_f = (paddr == `PFS_OFS_PORT_F);
	// Writes during the load cycle are held off by the wait state
	assign wr_d = commit && pwrite && hit_d;
	assign wr_e = commit && pwrite && hit_e;
	assign wr_f = commit && pwrite && hit_f;

	// Answer computation
	always_comb begin
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = 32'h00000000;
		if (access && !pready_reg) begin
			pready_next = 1'b1;
			// Unmapped address answers with an error
			pslverr_next = !(hit_d || hit_e || hit_f);
			if (!pwrite) begin
				// Read returns the stored word, upper half zero
				if (hit_d) begin
					prdata_next = {16'h0000, fn_d};
				end else if (hit_e) begin
					prdata_next = {16'h0000, fn_e};
				end else if (hit_f) begin
					prdata_next = {16'h0000, fn_f};
				end else begin
					prdata_next = 32'h00000000;
				end
			end
		end
	end

	// Answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// ==================================================================
	// Function registers, cleared by power-on reset only
	pfs_fn_reg #(
		.RESET_VAL(`PFS_RST_PORT_D)
	) u_reg_d (
		.pclk(pclk),
		.presetn(presetn),
		.load(1'b0),
		.load_val(16'h0000),
		.wr(wr_d),
		.lanes(pstrb[1:0]),
		.wdata(pwdata[15:0]),
		.value(fn_d)
	);

	pfs_fn_reg #(
		.RESET_VAL(`PFS_RST_PORT_E_NORMAL)
	) u_reg_e (
		.pclk(pclk),
		.presetn(presetn),
		.load(init_load),
		.load_val(load_e),
		.wr(wr_e),
		.lanes(pstrb[1:0]),
		.wdata(pwdata[15:0]),
		.value(fn_e)
	);

	pfs_fn_reg #(
		.RESET_VAL(`PFS_RST_PORT_F_NORMAL)
	) u_reg_f (
		.pclk(pclk),
		.presetn(presetn),
		.load(init_load),
		.load_val(load_f),
		.wr(wr_f),
		.lanes(pstrb[1:0]),
		.wdata(pwdata[15:0]),
		.value(fn_f)
	);

	// ==================================================================
	// Per-pin decoders; field n sits at bits 2n+1:2n
	genvar pin;
	generate
		for (pin = 0; pin < `PFS_PINS; pin++) begin : g_pin
			// Port D: pins 4 and 6 lack port output
			pfs_pin_decode #(
				.ALT_OK(1'(`PFS_D_ALT_MASK >> pin)),
				.OUT_OK(1'(`PFS_D_OUT_MASK >> pin))
			) u_dec_d (
				.pclk(pclk),
				.presetn(presetn),
				.mode(fn_d[2*pin+1 -: 2]),
				.alt_sel(port_d_alt_sel[pin]),
				.out_en(port_d_out_en[pin]),
				.pullup_en(port_d_pullup_en[pin])
			);
			// Port E: alternate function on pins 2, 4 and 5 only
			pfs_pin_decode #(
				.ALT_OK(1'(`PFS_E_ALT_MASK >> pin)),
				.OUT_OK(1'(`PFS_E_OUT_MASK >> pin))
			) u_dec_e (
				.pclk(pclk),
				.presetn(presetn),
				.mode(fn_e[2*pin+1 -: 2]),
				.alt_sel(port_e_alt_sel[pin]),
				.out_en(port_e_out_en[pin]),
				.pullup_en(port_e_pullup_en[pin])
			);
			// Port F: no port output on any pin
			pfs_pin_decode #(
				.ALT_OK(1'(`PFS_F_ALT_MASK >> pin)),
				.OUT_OK(1'(`PFS_F_OUT_MASK >> pin))
			) u_dec_f (
				.pclk(pclk),
				.presetn(presetn),
				.mode(fn_f[2*pin+1 -: 2]),
				.alt_sel(port_f_alt_sel[pin]),
				.out_en(port_f_out_en[pin]),
				.pullup_en(port_f_pullup_en[pin])
			);
		end
	endgenerate

	// ==================================================================
	// Outputs, all straight from flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign debug_mode = debug_mode_reg;
endmodule : pfs_pin_function_select

`default_nettype wire

//--- include/pfs_consts.svh
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// ==================================================================
// Register map (byte addresses on the APB)
`define PFS_ADDR_W 12
`define PFS_OFS_PORT_D 12'h000
`define PFS_OFS_PORT_E 12'h004
`define PFS_OFS_PORT_F 12'h008

// ==================================================================
// Register geometry
`define PFS_REG_W 16
`define PFS_PINS 8
`define PFS_FIELD_W 2

// ==================================================================
// Power-on values; E and F depend on the debug strap
`define PFS_RST_PORT_D 16'hAA8A
`define PFS_RST_PORT_E_NORMAL 16'hAAAA
`define PFS_RST_PORT_E_DEBUG 16'h2AA8
`define PFS_RST_PORT_F_NORMAL 16'hAAAA
`define PFS_RST_PORT_F_DEBUG 16'h00AA

// ==================================================================
// Mode field codes
`define PFS_MODE_ALT 2'h0
`define PFS_MODE_OUT 2'h1
`define PFS_MODE_IN_PU 2'h2
`define PFS_MODE_IN_NOPU 2'h3

// ==================================================================
// Per-pin capability masks (bit n set = pin n has that code)
`define PFS_D_ALT_MASK 8'hFF
`define PFS_D_OUT_MASK 8'hAF
`define PFS_E_ALT_MASK 8'h34
`define PFS_E_OUT_MASK 8'hFF
`define PFS_F_ALT_MASK 8'hFF
`define PFS_F_OUT_MASK 8'h00

`endif

//--- include/pfs_pkg.sv
`default_nettype none

// ==================================================================
// Shared types of the pin function select block
package pfs_pkg;
	// Phase of power-on initialisation
	typedef enum logic [0:0] {
		PFS_INIT_LOAD,
		PFS_INIT_RUN
	} pfs_init_t;
endpackage : pfs_pkg

`default_nettype wire

//--- rtl/pfs_fn_reg.sv
`include "pfs_consts.svh"
`default_nettype none

// ==================================================================
// One 16-bit function register with byte-lane writes and a
// one-shot load used to apply strap-dependent initial values
module pfs_fn_reg #(
	parameter logic [15:0] RESET_VAL = 16'h0000
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Power-on reset, active low
	input wire logic load, // Apply load_val this cycle
	input wire logic [15:0] load_val, // Strap-dependent initial value
	input wire logic wr, // Write strobe
	input wire logic [1:0] lanes, // Byte lanes to write
	input wire logic [15:0] wdata, // Write data
	output logic [15:0] value // Stored contents
);
	logic [15:0] value_reg; // Stored contents
	logic [15:0] value_next; // Next contents

	// ==================================================================
	// Next value: load wins, it only occurs before software runs
	always_comb begin
		value_next = value_reg;
		if (load) begin
			value_next = load_val;
		end else if (wr) begin
			if (lanes[0]) begin
				value_next[7:0] = wdata[7:0];
			end
			if (lanes[1]) begin
				value_next[15:8] = wdata[15:8];
			end
		end
	end

	// ==================================================================
	// Only power-on reset clears the register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= RESET_VAL;
		end else begin
			value_reg <= value_next;
		end
	end

	assign value = value_reg;
endmodule : pfs_fn_reg

`default_nettype wire

//--- rtl/pfs_pin_decode.sv
`include "pfs_consts.svh"
`default_nettype none

// ==================================================================
// Turns one 2-bit mode field into registered pin controls
module pfs_pin_decode #(
	parameter bit ALT_OK = 1'b1,
	parameter bit OUT_OK = 1'b1
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Power-on reset, active low
	input wire logic [1:0] mode, // Mode field of this pin
	output logic alt_sel, // Pin given to the peripheral
	output logic out_en, // Port output driver on
	output logic pullup_en // Input pull-up on
);
	logic alt_sel_reg; // Registered peripheral select
	logic out_en_reg; // Registered driver enable
	logic pullup_en_reg; // Registered pull-up enable
	logic alt_sel_next; // Decoded peripheral select
	logic out_en_next; // Decoded driver enable
	logic pullup_en_next; // Decoded pull-up enable

	// ==================================================================
	// Decode; a reserved code falls back to input with pull-up
	always_comb begin
		alt_sel_next = 1'b0;
		out_en_next = 1'b0;
		pullup_en_next = 1'b0;
		case (mode)
			`PFS_MODE_ALT: begin
				alt_sel_next = ALT_OK;
				pullup_en_next = !ALT_OK;
			end
			`PFS_MODE_OUT: begin
				out_en_next = OUT_OK;
				pullup_en_next = !OUT_OK;
			end
			`PFS_MODE_IN_PU: begin
				pullup_en_next = 1'b1;
			end
			default: begin
				pullup_en_next = 1'b0;
			end
		endcase
	end

	// ==================================================================
	// Controls reach the pad one cycle after the field changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_sel_reg <= 1'b0;
			out_en_reg <= 1'b0;
			pullup_en_reg <= 1'b0;
		end else begin
			alt_sel_reg <= alt_sel_next;
			out_en_reg <= out_en_next;
			pullup_en_reg <= pullup_en_next;
		end
	end

	assign alt_sel = alt_sel_reg;
	assign out_en = out_en_reg;
	assign pullup_en = pullup_en_reg;
endmodule : pfs_pin_decode

`default_nettype wire

//--- verification/pfs_props.sv
`default_nettype none

// ==================================================================
// Port-level checks of the pin function select block
module pfs_props (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic debug_mode_strap, // Strap pin
	input wire logic debug_mode, // Strapped mode
	input wire logic [7:0] port_d_alt_sel, // D peripheral
	input wire logic [7:0] port_d_out_en, // D output
	input wire logic [7:0] port_d_pullup_en, // D pull-up
	input wire logic [7:0] port_e_alt_sel, // E peripheral
	input wire logic [7:0] port_e_out_en, // E output
	input wire logic [7:0] port_e_pullup_en, // E pull-up
	input wire logic [7:0] port_f_alt_sel, // F peripheral
	input wire logic [7:0] port_f_out_en, // F output
	input wire logic [7:0] port_f_pullup_en // F pull-up
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [1:0] rel_cnt; // Edges since release, saturating
	logic [71:0] pins; // Alt, output, pull-up groups
	logic wr_done; // Accepted write to a mapped register
	logic strap_seen; // Strap level held while reset was low
	assign pins = {port_d_alt_sel, port_e_alt_sel, port_f_alt_sel,
		port_d_out_en, port_e_out_en, port_f_out_en,
		port_d_pullup_en, port_e_pullup_en, port_f_pullup_en};
	assign wr_done = pready && pwrite && !pslverr;

	// ==================================================================
	// Release counter: pins settle over two edges after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rel_cnt <= 2'h0;
		end else if (rel_cnt != 2'h3) begin
			rel_cnt <= rel_cnt + 2'h1;
		end
	end

	// Own strap capture; the pin may move freely after release
	always_ff @(posedge pclk) begin
		if (!presetn) begin
			strap_seen <= debug_mode_strap;
		end
	end

	// ==================================================================
	// Assertions
	chk_ready_one: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	chk_wait_state: assert property (
		psel && penable && !pready && !$past(penable) |=> pready)
		else $error("ready not one cycle into access");
	chk_err_map: assert property (
		pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
		else $error("error flag does not match address");
	chk_rdata_width: assert property (
		pready |-> prdata[31:16] == 16'h0000 && (!pslverr || prdata == 32'h0))
		else $error("read data outside register width");
	chk_pin_cause: assert property (
		rel_cnt == 2'h3 && $changed(pins) |-> $past(wr_done, 2))
		else $error("pin controls changed without a write");
	chk_pin_class: assert property (
		((pins[71:48] & pins[47:24]) | ((pins[71:48] | pins[47:24]) & pins[23:0])) == 24'h0)
		else $error("pin given two functions");
	chk_no_output: assert property (
		(port_d_out_en & 8'h50) == 8'h00 && port_f_out_en == 8'h00)
		else $error("output on a pin without output mode");
	chk_e_alt: assert property ((port_e_alt_sel & 8'hCB) == 8'h00)
		else $error("peripheral on a reserved port E pin");
	chk_strap_mode: assert property (rel_cnt == 2'h1 |-> debug_mode == !strap_seen)
		else $error("debug mode does not follow strap");
	chk_mode_hold: assert property (rel_cnt == 2'h3 |-> $stable(debug_mode))
		else $error("debug mode changed after reset");

	// ==================================================================
	// Coverage of the main traffic
	cov_write: cover property (wr_done);
	cov_read: cover property (pready && !pwrite && !pslverr);
	cov_error: cover property (pready && pslverr);
	cov_debug: cover property (rel_cnt == 2'h1 && debug_mode);
endmodule : pfs_props

`default_nettype wire

//--- verification/pfs_pin_function_select_tb_top.sv
`default_nettype none

// ==================================================================
// Self-checking bench of the pin function select block
module pfs_pin_function_select_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ALT_M [3] = '{8'hFF, 8'h34, 8'hFF}; // Pins with peripheral
	localparam logic [7:0] OUT_M [3] = '{8'hAF, 8'hFF, 8'h00}; // Pins with output
	logic pclk = 1'b0; // Clock
	logic presetn = 1'b0; // Reset
	logic psel = 1'b0; // APB select
	logic penable = 1'b0; // APB access
	logic pwrite = 1'b0; // APB direction
	logic [11:0] paddr = 12'h000; // APB address
	logic [31:0] pwdata = 32'h0; // APB data
	logic [3:0] pstrb = 4'h0; // APB strobes
	logic debug_mode_strap = 1'b1; // Strap
	logic [31:0] prdata; // Read data
	logic pready; // Ready
	logic pslverr; // Error
	logic debug_mode; // Strapped mode
	logic [7:0] pa [3]; // Alt select per port
	logic [7:0] po [3]; // Output enable per port
	logic [7:0] pu [3]; // Pull-up per port
	logic [15:0] mdl [3]; // Expected register contents
	logic [31:0] rd; // Last read data
	logic er; // Last error flag
	int fail_count = 0;
	int n_checks = 0;

	always #25 pclk = ~pclk;

	pfs_pin_function_select DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .debug_mode_strap, .debug_mode,
		.port_d_alt_sel(pa[0]), .port_d_out_en(po[0]), .port_d_pullup_en(pu[0]),
		.port_e_alt_sel(pa[1]), .port_e_out_en(po[1]), .port_e_pullup_en(pu[1]),
		.port_f_alt_sel(pa[2]), .port_f_out_en(po[2]), .port_f_pullup_en(pu[2]));

	// ==================================================================
	// Verdict and comparisons
	task automatic stop_test;
		if (fail_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t register got %h exp %h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_pins(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t pins got %h exp %h", $time, got, exp);
		end
	endtask : cmp_pins

	// Decode per pin; reserved codes fall back to pull-up input
	function automatic logic [23:0] exp_pins(input int p, input logic [15:0] v);
		logic [1:0] m;
		logic [7:0] a, o, u;
		for (int i = 0; i < 8; i++) begin
			m = v[2*i +: 2];
			a[i] = m == 2'h0 && ALT_M[p][i];
			o[i] = m == 2'h1 && OUT_M[p][i];
			u[i] = m == 2'h2 || (m == 2'h0 && !ALT_M[p][i]) || (m == 2'h1 && !OUT_M[p][i]);
		end
		return {a, o, u};
	endfunction : exp_pins

	// ==================================================================
	// APB master: holds the request until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16 && pready !== 1'b1; n++) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16) begin
			fail_count++;
			$display("[FAIL] %0t bus timeout", $time);
			stop_test();
		end
	endtask : apb

	// Write with byte lanes; port index 3 is an unmapped word
	task automatic wr(input int p, input logic [15:0] d, input logic [3:0] s);
		apb(1'b1, 12'(p * 4), d, s);
		if (p < 3) begin
			mdl[p] = {s[1] ? d[15:8] : mdl[p][15:8], s[0] ? d[7:0] : mdl[p][7:0]};
		end
		cmp_reg({31'h0, er}, {31'h0, p > 2});
	endtask : wr

	// Reads come first, so the pin flops have long settled
	task automatic chk_all;
		logic [23:0] e; // Expected pin groups
		for (int p = 0; p < 3; p++) begin
			apb(1'b0, 12'(p * 4), 16'h0000, 4'h0);
			cmp_reg(rd, {16'h0000, mdl[p]});
		end
		for (int p = 0; p < 3; p++) begin
			e = exp_pins(p, mdl[p]);
			cmp_pins({pa[p], po[p], pu[p]}, e);
		end
	endtask : chk_all

	task automatic do_reset(input logic s);
		presetn <= 1'b0;
		debug_mode_strap <= s;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Strap moves after release; the level seen in reset must hold
		debug_mode_strap <= !s;
		repeat (3) @(posedge pclk);
		mdl[0] = 16'hAA8A;
		mdl[1] = s ? 16'hAAAA : 16'h2AA8;
		mdl[2] = s ? 16'hAAAA : 16'h00AA;
		cmp_reg({31'h0, debug_mode}, {31'h0, !s});
	endtask : do_reset

	// ==================================================================
	// Main sequence
	initial begin
		void'($urandom(93297));
		do_reset(1'b1);
		chk_all();
		// Every code in every field of every port
		for (int p = 0; p < 3; p++) begin
			for (int c = 0; c < 4; c++) begin
				wr(p, 16'(16'h5555 * c), 4'h3);
				chk_all();
			end
		end
		// Single lane, no lane, then random traffic with unmapped words
		wr(1, 16'h0000, 4'h1);
		wr(2, 16'h0000, 4'h0);
		chk_all();
		for (int k = 0; k < 30; k++) begin
			wr(int'($urandom % 4), 16'($urandom), 4'($urandom));
			chk_all();
		end
		apb(1'b0, 12'h010, 16'h0000, 4'h0);
		cmp_reg({31'h0, er}, 32'h1);
		cmp_reg(rd, 32'h0);
		// Power-on again with the strap low
		do_reset(1'b0);
		chk_all();
		stop_test();
	end
endmodule : pfs_pin_function_select_tb_top

bind pfs_pin_function_select pfs_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .debug_mode_strap(debug_mode_strap), .debug_mode(debug_mode),
	.port_d_alt_sel(port_d_alt_sel), .port_d_out_en(port_d_out_en),
	.port_d_pullup_en(port_d_pullup_en), .port_e_alt_sel(port_e_alt_sel),
	.port_e_out_en(port_e_out_en), .port_e_pullup_en(port_e_pullup_en),
	.port_f_alt_sel(port_f_alt_sel), .port_f_out_en(port_f_out_en),
	.port_f_pullup_en(port_f_pullup_en));

`default_nettype wire
